// *** hw/supervisory_timer_pkg.sv ***
// constants, field layout and state type of the supervisory timer
// assumes a 32-bit AXI4-Lite slave port and a 40 MHz system clock
package supervisory_timer_pkg;

  // register map, byte addresses
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_OFFSET = 4'h0;
  localparam logic [3:0]  STAT_OFFSET = 4'h4;

  // watchdog_control fields
  localparam int          SEL_LSB     = 0;
  localparam int          SEL_W       = 3;
  localparam int          EN_BIT      = 3;
  localparam int          CHGEN_BIT   = 4;
  localparam logic [2:0]  RSVD_VALUE  = 3'h0;
  localparam logic [2:0]  SEL_RESET   = 3'h0;

  // reset status field
  localparam int          FLAG_BIT    = 3;

  // timing
  localparam int          SYS_CLK_HZ        = 40_000_000;
  localparam int          OSC_NOM_HZ        = 1_000_000;
  localparam logic [2:0]  CHG_WINDOW_CYCLES = 3'h4;
  localparam int          BASE_TIMEOUT      = 16_384;
  localparam int          CNT_W             = 22;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SAFETY0, SAFETY1, SAFETY2} level_e;

  typedef struct packed {
    logic [2:0]        oscSync;
    logic              oscLvl;
    logic              fuseCompat;
    logic              fuseOn;
    logic              enable;
    logic [SEL_W-1:0]  sel;
    logic [2:0]        chgCnt;
    logic [CNT_W-1:0]  cnt;
    logic              rstPulse;
    logic              flag;
    logic              awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic              wHeld;
    logic [7:0]        wData;
    logic              wStrb0;
    logic              awRdy;
    logic              wRdy;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arRdy;
    logic              rValid;
    logic [7:0]        rData;
    logic [1:0]        rResp;
  } wd_state_s;

endpackage

// *** hw/fuse_protected_watchdog_timer.sv ***
// supervisory timer with fuse-selected safety levels, AXI4-Lite registers
// assumes the watchdog oscillator arrives as a free-running pin, fuses are static
// What this block does
// - counter runs from separate ~1 MHz oscillator
// - restart instruction clears the counter
// - disable or chip reset clears the counter
// - expired time-out while enabled resets the chip
// - two fuses select safety level 0,1,2
// - levels 0 and 1 start disabled
// - enable write always accepted, no sequence
// - control bits 7..5 read as zero
// - change-enable self-clears four cycles after write
// - enable clear ignored unless change-enable set
// - level 2 never disables the watchdog
// - level 2 enable always reads one
// - select gives 16384 doubling to 2097152 cycles
// - level 0 changes select on any write
// - levels 1,2 change select only in window
// - level 2 follow-up write ignores enable value
// - time-out issues one-cycle reset pulse
// - reset flag set on time-out, cleared softly
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module fuse_protected_watchdog_timer #(
  parameter int BaseTimeout = supervisory_timer_pkg::BASE_TIMEOUT
) (
  input  wire logic                                     ref_clk,
  input  wire logic                                     resetn,
  input  wire logic                                     powerOnReset,
  input  wire logic                                     wdOsc,
  input  wire logic                                     restartInstr,
  input  wire logic                                     legacyCompatFuse,
  input  wire logic                                     alwaysOnFuse,
  output logic                                          chipResetPulse,
  output logic                                          timeoutResetFlag,
  input  wire logic [supervisory_timer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                                     s_axi_awvalid,
  output logic                                          s_axi_awready,
  input  wire logic [31:0]                              s_axi_wdata,
  input  wire logic [3:0]                               s_axi_wstrb,
  input  wire logic                                     s_axi_wvalid,
  output logic                                          s_axi_wready,
  output logic [1:0]                                    s_axi_bresp,
  output logic                                          s_axi_bvalid,
  input  wire logic                                     s_axi_bready,
  input  wire logic [supervisory_timer_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                                     s_axi_arvalid,
  output logic                                          s_axi_arready,
  output logic [31:0]                                   s_axi_rdata,
  output logic [1:0]                                    s_axi_rresp,
  output logic                                          s_axi_rvalid,
  input  wire logic                                     s_axi_rready
);

  supervisory_timer_pkg::wd_state_s  s_r;
  supervisory_timer_pkg::wd_state_s  s_nxt;
  supervisory_timer_pkg::level_e     level;
  logic                              effEn;
  logic                              chgOpen;
  logic                              oscEdge;
  logic [supervisory_timer_pkg::CNT_W-1:0] limit;
  logic                              doWrite;
  logic                              ctrlHit;
  logic                              statHit;
  logic [7:0]                        wd;

  always_comb begin
    // fuse decode; always-on dominates the compat fuse
    if (s_r.fuseOn) begin
      level = supervisory_timer_pkg::SAFETY2;
    end else if (s_r.fuseCompat) begin
      level = supervisory_timer_pkg::SAFETY0;
    end else begin
      level = supervisory_timer_pkg::SAFETY1;
    end
    effEn   = s_r.enable | (level == supervisory_timer_pkg::SAFETY2);
    chgOpen = (s_r.chgCnt != 3'h0);
    // only the second and third stage are looked at, never the first
    oscEdge = (s_r.oscSync[1] == s_r.oscSync[2]) & s_r.oscSync[1] & ~s_r.oscLvl;
    limit   = supervisory_timer_pkg::CNT_W'(BaseTimeout) << s_r.sel;
    doWrite = s_r.awHeld & s_r.wHeld & ~s_r.bValid;
    ctrlHit = (s_r.awAddr == supervisory_timer_pkg::CTRL_OFFSET);
    statHit = (s_r.awAddr == supervisory_timer_pkg::STAT_OFFSET);
    wd      = s_r.wData;

    s_nxt = s_r;
    s_nxt.rstPulse = 1'b0;
    s_nxt.oscSync  = {s_r.oscSync[1:0], wdOsc};
    if (s_r.oscSync[1] == s_r.oscSync[2]) begin
      s_nxt.oscLvl = s_r.oscSync[1];
    end
    if (chgOpen) begin
      s_nxt.chgCnt = s_r.chgCnt - 3'h1;
    end

    // write address and data are taken independently, in either order
    if (s_axi_awvalid && s_r.awRdy) begin
      s_nxt.awHeld = 1'b1;
      s_nxt.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wRdy) begin
      s_nxt.wHeld  = 1'b1;
      s_nxt.wData  = s_axi_wdata[7:0];
      s_nxt.wStrb0 = s_axi_wstrb[0];
    end
    if (s_r.bValid && s_axi_bready) begin
      s_nxt.bValid = 1'b0;
    end

    if (doWrite) begin
      s_nxt.awHeld = 1'b0;
      s_nxt.wHeld  = 1'b0;
      s_nxt.bValid = 1'b1;
      s_nxt.bResp  = (ctrlHit || statHit) ? supervisory_timer_pkg::RESP_OKAY
                                          : supervisory_timer_pkg::RESP_SLVERR;
      if (ctrlHit && s_r.wStrb0) begin
        if (wd[supervisory_timer_pkg::EN_BIT]) begin
          s_nxt.enable = 1'b1;
        end else if (chgOpen && level != supervisory_timer_pkg::SAFETY2) begin
          s_nxt.enable = 1'b0;
        end
        // select only moves inside the window unless level 0
        if (level == supervisory_timer_pkg::SAFETY0 || chgOpen) begin
          s_nxt.sel = wd[supervisory_timer_pkg::SEL_LSB +: supervisory_timer_pkg::SEL_W];
        end
        if (wd[supervisory_timer_pkg::CHGEN_BIT]) begin
          s_nxt.chgCnt = supervisory_timer_pkg::CHG_WINDOW_CYCLES;
        end
      end
      if (statHit && s_r.wStrb0 && !wd[supervisory_timer_pkg::FLAG_BIT]) begin
        s_nxt.flag = 1'b0;
      end
    end

    // counter; a time-out below overrides the flag clear above
    if (restartInstr) begin
      s_nxt.cnt = '0;
    end else if (!(s_nxt.enable || level == supervisory_timer_pkg::SAFETY2)) begin
      s_nxt.cnt = '0;
    end else if (oscEdge) begin
      if (s_r.cnt == limit - 1'b1) begin
        s_nxt.cnt      = '0;
        s_nxt.rstPulse = 1'b1;
        s_nxt.flag     = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end

    // read channel answers one cycle after the address is taken
    if (s_r.rValid && s_axi_rready) begin
      s_nxt.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_r.arRdy) begin
      s_nxt.rValid = 1'b1;
      s_nxt.rResp  = supervisory_timer_pkg::RESP_OKAY;
      s_nxt.rData  = 8'h00;
      if (s_axi_araddr == supervisory_timer_pkg::CTRL_OFFSET) begin
        s_nxt.rData = {supervisory_timer_pkg::RSVD_VALUE, chgOpen, effEn, s_r.sel};
      end else if (s_axi_araddr == supervisory_timer_pkg::STAT_OFFSET) begin
        s_nxt.rData[supervisory_timer_pkg::FLAG_BIT] = s_r.flag;
      end else begin
        s_nxt.rResp = supervisory_timer_pkg::RESP_SLVERR;
      end
    end
    s_nxt.awRdy = ~s_nxt.awHeld & ~s_nxt.bValid;
    s_nxt.wRdy  = ~s_nxt.wHeld & ~s_nxt.bValid;
    s_nxt.arRdy = ~s_nxt.rValid;

    // chip reset; the flag survives it, only power-on clears it
    if (!resetn) begin
      s_nxt            = '0;
      s_nxt.sel        = supervisory_timer_pkg::SEL_RESET;
      s_nxt.enable     = 1'b0;
      s_nxt.cnt        = '0;
      s_nxt.fuseCompat = legacyCompatFuse;
      s_nxt.fuseOn     = alwaysOnFuse;
      s_nxt.flag       = powerOnReset ? 1'b0 : s_r.flag;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  assign chipResetPulse   = s_r.rstPulse;
  assign timeoutResetFlag = s_r.flag;
  assign s_axi_awready    = s_r.awRdy;
  assign s_axi_wready     = s_r.wRdy;
  assign s_axi_bvalid     = s_r.bValid;
  assign s_axi_bresp      = s_r.bResp;
  assign s_axi_arready    = s_r.arRdy;
  assign s_axi_rvalid     = s_r.rValid;
  assign s_axi_rresp      = s_r.rResp;
  assign s_axi_rdata      = {24'h000000, s_r.rData};

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  pulse_width_a: assert property (
    s_r.rstPulse |=> !s_r.rstPulse && s_r.cnt == '0)
    else $error("reset pulse longer than one cycle");

  window_close_a: assert property (
    (s_r.chgCnt == 3'h1 && !doWrite) |=> s_r.chgCnt == 3'h0)
    else $error("change window did not close");

  reserved_zero_a: assert property (
    s_r.rValid |-> s_r.rData[7:5] == 3'h0)
    else $error("reserved bits read nonzero");

  level2_on_a: assert property (
    (level == supervisory_timer_pkg::SAFETY2 && oscEdge && !restartInstr && s_r.cnt != limit - 1'b1)
    |=> s_r.cnt == $past(s_r.cnt) + 1'b1)
    else $error("level 2 watchdog not running");

  restart_clear_a: assert property (
    restartInstr |=> s_r.cnt == '0)
    else $error("restart did not clear counter");

  disabled_clear_a: assert property (
    (!s_r.enable && level != supervisory_timer_pkg::SAFETY2) |-> s_r.cnt == '0)
    else $error("disabled counter not zero");

  flag_set_a: assert property (
    s_r.rstPulse |-> s_r.flag)
    else $error("timeout flag not set with reset pulse");

  sel_locked_a: assert property (
    (level != supervisory_timer_pkg::SAFETY0 && !chgOpen) |=> s_r.sel == $past(s_r.sel))
    else $error("select changed outside window");

  enable_hold_a: assert property (
    (s_r.enable && !chgOpen) |=> s_r.enable)
    else $error("enable cleared without change window");

  bresp_hold_a: assert property (
    (s_r.bValid && !s_axi_bready) |=> s_r.bValid && $stable(s_r.bResp))
    else $error("write response dropped early");

endmodule

`default_nettype wire

// *** verif/core_model.sv ***
// cpu core stand-in: watchdog oscillator and restart instruction pulses
// assumes the bench calls restart() between its own bus accesses
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic ref_clk,
  output logic      wdOsc,
  output logic      restartInstr
);
  // free running, phase unrelated to ref_clk
  initial begin
    wdOsc = 1'b0;
    restartInstr = 1'b0;
    #137;
    forever #500 wdOsc = ~wdOsc;
  end
  task automatic restart();
    @(posedge ref_clk);
    restartInstr <= 1'b1;
    @(posedge ref_clk);
    restartInstr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/test_fuse_protected_watchdog_timer.sv ***
// bench: fuse levels, timed sequences, time-out and flag, random selects
// assumes BaseTimeout 4, so a time-out spans a few hundred clocks
`timescale 1ns/1ps
`default_nettype none
module test_fuse_protected_watchdog_timer;
  localparam logic [3:0] CTRL = supervisory_timer_pkg::CTRL_OFFSET;
  localparam logic [3:0] STAT = supervisory_timer_pkg::STAT_OFFSET;
  logic        ref_clk, resetn, powerOnReset, compatFuse, onFuse, wdOsc, restartInstr, chipResetPulse, flag;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [3:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic [2:0]  sel;
  logic        en;
  int          lv, n, mismatches, compares;

  fuse_protected_watchdog_timer #(.BaseTimeout(4)) dut (
    .ref_clk(ref_clk), .resetn(resetn), .powerOnReset(powerOnReset), .wdOsc(wdOsc),
    .restartInstr(restartInstr), .legacyCompatFuse(compatFuse), .alwaysOnFuse(onFuse),
    .chipResetPulse(chipResetPulse), .timeoutResetFlag(flag),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
  );
  core_model core (.ref_clk(ref_clk), .wdOsc(wdOsc), .restartInstr(restartInstr));

  task automatic chk(logic [31:0] got, logic [31:0] exp, string what);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %0h want %0h", $time, what, got, exp);
    end
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic hang(string what);
    mismatches++;
    $display("unexpected at %0t: %s hung", $time, what);
    close_out();
  endtask
  // handshakes judged at the falling edge, acted on at the next rising edge
  task automatic wr(logic [3:0] a, logic [7:0] v);
    logic [2:0] t;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= {24'h0, v};
    {awvalid, wvalid, bready} <= 3'h7;
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      t = {awvalid & awready, wvalid & wready, bvalid};
      @(posedge ref_clk);
      if (t[2]) awvalid <= 1'b0;
      if (t[1]) wvalid <= 1'b0;
      if (t[0]) begin
        bready <= 1'b0;
        return;
      end
    end
    hang("write");
  endtask
  task automatic rd(logic [3:0] a);
    logic [1:0] t;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (int i = 0; i < 60; i++) begin
      @(negedge ref_clk);
      t = {arvalid & arready, rvalid};
      d = rdata;
      r = rresp;
      @(posedge ref_clk);
      if (t[1]) arvalid <= 1'b0;
      if (t[0]) begin
        rready <= 1'b0;
        return;
      end
    end
    hang("read");
  endtask
  // control write plus the expected effect on enable and select
  task automatic put(logic [7:0] v, logic win);
    wr(CTRL, v);
    if (lv == 2 || v[3]) en = 1'b1;
    else if (win) en = 1'b0;
    if (lv == 0 || win) sel = v[2:0];
  endtask
  // waits out any open window so change-enable reads back zero
  task automatic chkCtrl();
    repeat (6) @(posedge ref_clk);
    rd(CTRL);
    chk(d, {28'h0, en, sel}, "control");
  endtask
  task automatic doReset(logic por);
    @(posedge ref_clk);
    {resetn, powerOnReset} <= {1'b0, por};
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  // oscillator is 40 clocks; slack covers phase and synchroniser delay
  function automatic logic inTime(int cyc, int k);
    return cyc >= ((4 << k) - 1) * 40 && cyc <= (4 << k) * 40 + 8;
  endfunction

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (100000) @(posedge ref_clk);
    hang("run");
  end
  initial begin
    {resetn, powerOnReset, compatFuse, onFuse} = 4'h4;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 40'h0;
    mismatches = 0;
    compares = 0;
    void'($urandom(42930));
    for (int i = 0; i < 4; i++) begin
      {compatFuse, onFuse} <= {i == 0 || i == 3, i[1]};
      lv = i[1] ? 2 : (i == 0 ? 0 : 1);
      doReset(1'b1);
      en = (lv == 2);
      sel = 3'h0;
      chkCtrl();
      put({5'h0, 3'($urandom_range(7, 1))}, 1'b0);
      chkCtrl();
      put({5'h1, 3'($urandom())}, 1'b0);
      chkCtrl();
      put(8'h00, 1'b0);
      chkCtrl();
      put({5'h3, sel}, 1'b0);
      repeat (8) @(posedge ref_clk);
      put({5'h0, sel}, 1'b0);
      chkCtrl();
      put({5'h3, sel}, 1'b0);
      put({5'h0, 3'($urandom())}, 1'b1);
      chkCtrl();
      $display("level %0d test done", lv);
    end
    {compatFuse, onFuse} <= 2'h2;
    lv = 0;
    doReset(1'b1);
    for (int k = 0; k < 2; k++) begin
      put({5'h1, 3'(k)}, 1'b0);
      repeat (8) begin
        repeat (30) @(posedge ref_clk);
        core.restart();
      end
      for (n = 0; n < 800 && chipResetPulse !== 1'b1; n++) @(negedge ref_clk);
      chk({31'h0, inTime(n, k)}, 32'h1, "time-out");
      @(negedge ref_clk);
      chk({31'h0, chipResetPulse}, 32'h0, "pulse width");
      chk({31'h0, flag}, 32'h1, "flag pin");
    end
    $display("time-out test done");
    doReset(1'b0);
    rd(STAT);
    chk(d, 32'h8, "flag kept");
    wr(STAT, 8'h00);
    rd(STAT);
    chk(d, 32'h0, "flag cleared");
    rd(4'h8);
    chk({r, d[29:0]}, {supervisory_timer_pkg::RESP_SLVERR, 30'h0}, "unmapped");
    close_out();
  end
endmodule
`default_nettype wire
